// ===== verilog/fifo_flag_pkg.sv
// constants for the fifo status flag register block
// assumes a 32-bit classic wishbone slave on a single clock
package fifo_flag_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] status_enable_addr = 4'h0;
  localparam logic [3:0] occupancy_addr     = 4'h4;
  // ---------------------------------------------------------------
  // flag bit positions in the status half, the enable shift and the direction bit
  // ---------------------------------------------------------------
  localparam int rx_not_empty_bit  = 0;
  localparam int rx_half_full_bit  = 1;
  localparam int rx_full_bit       = 2;
  localparam int rx_overflow_bit   = 3;
  localparam int tx_empty_bit      = 8;
  localparam int tx_half_empty_bit = 9;
  localparam int enable_shift      = 16;
  localparam int direction_bit     = 31;
  // ---------------------------------------------------------------
  // writable fields and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] enable_mask     = 16'h030f;
  localparam logic [15:0] enable_reset    = 16'h0000;
  localparam logic        direction_reset = 1'b0;
  // ---------------------------------------------------------------
  // default fifo depth
  // ---------------------------------------------------------------
  localparam int default_depth = 32;
endpackage

// ===== verilog/flag_decode.sv
// combinational-free decoder of occupancy into registered flag levels
// assumes occupancy comes from logic on the same clock
module flag_decode #(
  parameter int depth = fifo_flag_pkg::default_depth
) (
  input  wire logic                       clk_i,       // clock
  input  wire logic                       rst_i,       // sync reset
  input  wire logic [$clog2(depth+1)-1:0] count_i,     // messages held
  output logic                            empty_o,     // none held
  output logic                            full_o,      // every slot held
  output logic                            low_half_o,  // at or below half
  output logic                            high_half_o  // at or above half
);
  localparam logic [$clog2(depth+1)-1:0] half = ($clog2(depth+1))'(depth / 2);
  localparam logic [$clog2(depth+1)-1:0] all  = ($clog2(depth+1))'(depth);

  logic nxt_empty, nxt_full, nxt_low, nxt_high;
  logic empty_ff, full_ff, low_ff, high_ff;

  always_comb
  begin
    nxt_empty = (count_i == '0);
    nxt_full  = (count_i == all);
    nxt_low   = (count_i <= half);
    nxt_high  = (count_i >= half);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      empty_ff <= 1'b1;
      full_ff  <= 1'b0;
      low_ff   <= 1'b1;
      high_ff  <= 1'b0;
    end
    else
    begin
      empty_ff <= nxt_empty;
      full_ff  <= nxt_full;
      low_ff   <= nxt_low;
      high_ff  <= nxt_high;
    end
  end

  assign empty_o     = empty_ff;
  assign full_o      = full_ff;
  assign low_half_o  = low_ff;
  assign high_half_o = high_ff;
endmodule

// ===== verilog/can_fifo_status_flags.sv
// status flag and interrupt enable register of one can message fifo
// assumes occupancy and overflow event come from logic on clk_i
// How it works
// - in transmit mode the half-empty flag is set while occupancy is at or below half.
// - in transmit mode the empty flag is set only while no message is queued.
// - in receive mode the overflow flag is set once an overflow event occurs.
// - in receive mode the full flag is set exactly while every slot is used.
// - in receive mode the half-full flag is set while occupancy is at or above half.
// - in receive mode the not-empty flag is set while at least one message is held.
// - flags of the direction not selected read as zero.
// - bits seven to four are unimplemented and read zero.
// - the live flags are read-only except overflow, which a zero written to bit 3 clears.
// - the upper half holds one writable enable per flag that gates its request.
module can_fifo_status_flags #(
  parameter int depth = fifo_flag_pkg::default_depth
) (
  input  wire logic                       clk_i,         // clock, 10 mhz
  input  wire logic                       rst_i,         // sync reset, high
  input  wire logic [3:0]                 adr_i,         // wishbone byte address
  input  wire logic [31:0]                dat_i,         // wishbone write data
  input  wire logic [3:0]                 sel_i,         // wishbone byte lanes
  input  wire logic                       we_i,          // wishbone write
  input  wire logic                       cyc_i,         // wishbone cycle
  input  wire logic                       stb_i,         // wishbone strobe
  input  wire logic [$clog2(depth+1)-1:0] count_i,       // fifo occupancy
  input  wire logic                       overflow_i,    // overflow event pulse
  output logic [31:0]                     dat_o,         // wishbone read data
  output logic                            ack_o,         // wishbone ack
  output logic                            direction_is_transmit_o, // direction bit
  output logic                            flag_request_o // enabled flag pending
);
  // ---------------------------------------------------------------
  // occupancy decode
  // ---------------------------------------------------------------
  logic occ_empty, occ_full, occ_low, occ_high;

  flag_decode #(
    .depth (depth)
  ) u_decode (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .count_i     (count_i),
    .empty_o     (occ_empty),
    .full_o      (occ_full),
    .low_half_o  (occ_low),
    .high_half_o (occ_high)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic        dir_ff, nxt_dir;
  logic [15:0] enable_ff, nxt_enable;
  logic        ovfl_ff, nxt_ovfl;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        req_ff, nxt_req;
  logic [15:0] flags;
  logic        access;
  logic        wr_status;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  lanes);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // live flags
  // ---------------------------------------------------------------
  always_comb
  begin
    flags = 16'h0000; // bits 7:4 and the rest stay zero
    if (dir_ff)
    begin
      flags[fifo_flag_pkg::tx_half_empty_bit] = occ_low;
      flags[fifo_flag_pkg::tx_empty_bit]      = occ_empty;
    end
    else
    begin
      flags[fifo_flag_pkg::rx_overflow_bit]  = ovfl_ff;
      flags[fifo_flag_pkg::rx_full_bit]      = occ_full;
      flags[fifo_flag_pkg::rx_half_full_bit] = occ_high;
      flags[fifo_flag_pkg::rx_not_empty_bit] = ~occ_empty;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic rd_access;

  function automatic logic addr_hit(input logic [3:0] adr,
                                    input logic [3:0] offset);
    return adr == offset;
  endfunction

  always_comb
  begin
    // ack high blocks a second take of the same request
    access    = cyc_i & stb_i & ~ack_ff;
    wr_status = access & we_i & addr_hit(adr_i, fifo_flag_pkg::status_enable_addr);
    rd_access = access & ~we_i;
  end

  // ---------------------------------------------------------------
  // direction and interrupt enables
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [31:0] merged;
    merged     = 32'h0000_0000;
    nxt_dir    = dir_ff;
    nxt_enable = enable_ff;
    if (wr_status)
    begin
      // untouched lanes keep their old bits
      merged     = lane_merge({dir_ff, 15'h0000, 16'h0000} |
                              {16'h0000, enable_ff} << fifo_flag_pkg::enable_shift,
                              dat_i, sel_i);
      nxt_enable = merged[31:16] & fifo_flag_pkg::enable_mask;
      nxt_dir    = merged[fifo_flag_pkg::direction_bit];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_ff    <= fifo_flag_pkg::direction_reset;
      enable_ff <= fifo_flag_pkg::enable_reset;
    end
    else
    begin
      dir_ff    <= nxt_dir;
      enable_ff <= nxt_enable;
    end
  end

  // ---------------------------------------------------------------
  // sticky overflow
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ovfl = ovfl_ff;
    // a zero at bit 3 of lane 0 clears; a same-cycle event wins in receive mode only
    if (wr_status && sel_i[0] && !dat_i[fifo_flag_pkg::rx_overflow_bit])
      nxt_ovfl = 1'b0;
    if (overflow_i && !dir_ff)
      nxt_ovfl = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovfl_ff <= 1'b0;
    else
      ovfl_ff <= nxt_ovfl;
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ack   = access;
    nxt_rdata = 32'h0000_0000;
    if (rd_access)
    begin
      if (addr_hit(adr_i, fifo_flag_pkg::status_enable_addr))
        nxt_rdata = {enable_ff & ~(16'h8000), flags};
      else if (addr_hit(adr_i, fifo_flag_pkg::occupancy_addr))
        nxt_rdata = {dir_ff, 31'(count_i)};
      else
        nxt_rdata = 32'h0000_0000; // unmapped reads give zero
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // enable-gated flag request
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_req = |(enable_ff & flags);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req_ff <= 1'b0;
    else
      req_ff <= nxt_req;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign dat_o                   = rdata_ff;
  assign ack_o                   = ack_ff;
  assign direction_is_transmit_o = dir_ff;
  assign flag_request_o          = req_ff;
endmodule

// ===== sim/can_fifo_flags_props.sv
// assertions on the ports of the fifo status flag block
// assumes a bind to can_fifo_status_flags, one clock, sync reset
module can_fifo_flags_props #(
  parameter int depth = fifo_flag_pkg::default_depth
) (
  input logic                       clk_i,      // clock
  input logic                       rst_i,      // reset
  input logic [3:0]                 adr_i,      // address
  input logic                       we_i,       // write
  input logic                       cyc_i,      // cycle
  input logic                       stb_i,      // strobe
  input logic [$clog2(depth+1)-1:0] count_i,    // occupancy
  input logic                       overflow_i, // overflow pulse
  input logic [31:0]                dat_o,      // read data
  input logic                       ack_o,      // ack
  input logic                       direction_is_transmit_o // direction
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd;
  logic tx;
  logic calm_ff;
  // ---------------------------------------------------------------
  // status read answered with occupancy held long enough
  // ---------------------------------------------------------------
  assign rd = ack_o && cyc_i && !we_i && adr_i == fifo_flag_pkg::status_enable_addr;
  assign tx = direction_is_transmit_o;
  always_ff @(posedge clk_i)
    calm_ff <= !$past(rst_i) && $past(count_i) == count_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  tx_half_a: assert property (rd && calm_ff && $stable(count_i) && tx
    |-> dat_o[9] == (count_i <= depth / 2)) else $error("tx half flag wrong");
  tx_empty_a: assert property (rd && calm_ff && $stable(count_i) && tx
    |-> dat_o[8] == (count_i == 0)) else $error("tx empty flag wrong");
  rx_full_a: assert property (rd && calm_ff && $stable(count_i) && !tx
    |-> dat_o[2] == (count_i == depth)) else $error("rx full flag wrong");
  rx_half_a: assert property (rd && calm_ff && $stable(count_i) && !tx
    |-> dat_o[1] == (count_i >= depth / 2)) else $error("rx half flag wrong");
  rx_nempty_a: assert property (rd && calm_ff && $stable(count_i) && !tx
    |-> dat_o[0] == (count_i != 0)) else $error("rx not empty flag wrong");
  cross_zero_a: assert property (rd |-> (tx ? dat_o[3:0] : dat_o[9:8]) == '0)
    else $error("unselected flags not zero");
  unimpl_zero_a: assert property (rd |-> dat_o[7:4] == 4'h0)
    else $error("unimplemented bits not zero");
  ovfl_set_a: assert property (rd && $past(overflow_i, 3) && !$past(tx, 3)
    && !$past(rst_i, 2) && !$past(rst_i, 3) |-> dat_o[3]) else $error("overflow not set");
  ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
endmodule

// ===== sim/can_fifo_status_flags_tb_top.sv
// self-checking bench for the fifo status flag block
// assumes the design package and the checker are compiled first
module can_fifo_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int D = 8;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, overflow_i, ack_o, dir_o, req_o;
  logic [3:0]  adr_i, sel_i, count_i;
  logic [31:0] dat_i, dat_o, q;
  int          err_count, compares;
  int          cs[5] = '{0, 3, 4, 5, 8};
  can_fifo_status_flags #(.depth(D)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .count_i(count_i), .overflow_i(overflow_i), .dat_o(dat_o), .ack_o(ack_o),
    .direction_is_transmit_o(dir_o), .flag_request_o(req_o));
  // ---------------------------------------------------------------
  // bus and check helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    {adr_i, we_i, dat_i, sel_i, cyc_i, stb_i} <= {a, w, d, s, 2'b11};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    chk(q, e);
  endtask
  task automatic setc(input int c);
    @(posedge clk_i);
    count_i <= c[3:0];
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse();
    @(posedge clk_i);
    overflow_i <= 1'b1;
    @(posedge clk_i);
    overflow_i <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_rx();
    foreach (cs[i])
    begin
      setc(cs[i]);
      rd(4'h0, {29'h0, cs[i] == D, cs[i] >= D / 2, cs[i] != 0});
    end
  endtask
  task automatic t_ovf();
    setc(3);
    pulse();
    rd(4'h0, 32'h9);
    wb(4'h0, 1'b1, 32'h0000_ffff, 4'h3);
    rd(4'h0, 32'h9);
    setc(0);
    rd(4'h0, 32'h8);
    wb(4'h0, 1'b1, 32'h0, 4'h1);
    rd(4'h0, 32'h0);
  endtask
  task automatic t_tx();
    wb(4'h0, 1'b1, 32'h8000_0000, 4'h8);
    chk({31'h0, dir_o}, 32'h1);
    rd(4'h4, 32'h8000_0000);
    foreach (cs[i])
    begin
      setc(cs[i]);
      rd(4'h0, {22'h0, cs[i] <= D / 2, cs[i] == 0, 8'h00});
    end
    pulse();
    wb(4'h0, 1'b1, 32'h0, 4'h8);
    rd(4'h0, 32'h7);
  endtask
  task automatic t_en();
    setc(3);
    wb(4'h0, 1'b1, 32'h7fff_0000, 4'hc);
    rd(4'h0, 32'h030f_0001);
    chk({31'h0, req_o}, 32'h1);
    wb(4'h0, 1'b1, 32'h0, 4'hc);
    repeat (2) @(posedge clk_i);
    chk({31'h0, req_o}, 32'h0);
    rd(4'h8, 32'h0);
  endtask
  task automatic t_rst();
    pulse();
    wb(4'h0, 1'b1, 32'h830f_0000, 4'hc);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, dir_o}, 32'h0);
    rd(4'h0, 32'h0000_0001);
    chk({31'h0, req_o}, 32'h0);
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, we_i, cyc_i, stb_i, overflow_i} = 5'b10000;
    {adr_i, sel_i, count_i, dat_i} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rx();
    t_ovf();
    t_tx();
    t_en();
    t_rst();
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    test_done();
  end
endmodule
bind can_fifo_status_flags can_fifo_flags_props #(.depth(depth)) props (.clk_i(clk_i),
  .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .count_i(count_i), .overflow_i(overflow_i), .dat_o(dat_o), .ack_o(ack_o),
  .direction_is_transmit_o(direction_is_transmit_o));
